// *** include/dvig_pkg.sv ***
// package: constants and types for the dual interrupt generator
package dvig_pkg;
  localparam int unsigned NUM_GEN   = 2;
  localparam int unsigned NUM_EVT   = 6;
  localparam int unsigned PRIO_W    = 3;
  localparam int unsigned LEVELS    = 7;
  localparam int unsigned STATID_W  = 8;

  // event bit positions within a mask
  localparam int unsigned EVT_FIFO_NOT_EMPTY = 0;
  localparam int unsigned EVT_BLOCK_READY    = 1;
  localparam int unsigned EVT_ARMED_WAITING  = 2;
  localparam int unsigned EVT_ACQ_DONE       = 3;
  localparam int unsigned EVT_INPUT_OVERRANGE = 4;
  localparam int unsigned EVT_CONVERTER_FAULT = 5;

  localparam logic [NUM_EVT-1:0]  MASK_RESET = 6'h00;
  localparam logic [PRIO_W-1:0]   PRIO_OFF   = 3'h0;
  localparam logic [PRIO_W-1:0]   PRIO_RESET = 3'h0;
  localparam logic [LEVELS-1:0]   LEVELS_NONE = 7'h00;
  localparam logic [STATID_W-1:0] STATID_RESET = 8'h00;

  typedef logic [NUM_EVT-1:0] dvig_mask_t;
  typedef logic [PRIO_W-1:0]  dvig_prio_t;

  typedef enum logic [1:0] {
    DVIG_IDLE    = 2'b00,
    DVIG_REQUEST = 2'b01,
    DVIG_ACKED   = 2'b10
  } dvig_state_t;

  // one-hot request line for a priority; priority 0 gives no line
  function automatic logic [LEVELS-1:0] dvig_level_onehot(input dvig_prio_t p);
    logic [LEVELS-1:0] r;
    r = LEVELS_NONE;
    if (p != PRIO_OFF) begin
      r[p - 3'h1] = 1'b1;
    end
    return r;
  endfunction : dvig_level_onehot
endpackage : dvig_pkg

// *** include/dvig_gen_if.sv ***
// interface: settings and request path between top and one generator
`timescale 1ns/1ps
`default_nettype none
interface dvig_gen_if;
  import dvig_pkg::*;
  dvig_mask_t        mask;
  dvig_prio_t        prio;
  logic [NUM_EVT-1:0] events;
  logic              iack_hit;
  logic              active;
  logic [LEVELS-1:0] irq_lines;
  modport top (output mask, prio, events, iack_hit, input active, irq_lines);
  modport gen (input mask, prio, events, iack_hit, output active, irq_lines);
endinterface : dvig_gen_if
`default_nettype wire

// *** hdl/dvig_generator.sv ***
// module: one interrupt generator with request/acknowledge sequencing
`timescale 1ns/1ps
`default_nettype none
module dvig_generator
  import dvig_pkg::*;
(
  input  wire logic  clk,    // module clock
  input  wire logic  rst_b,  // async reset, active low
  input  wire logic  ce,     // clock enable
  dvig_gen_if.gen    gi      // settings and request path
);
  dvig_state_t state;
  dvig_state_t next_state;
  logic        hit;

  // ****************************************************************
  // request sequencing
  // ****************************************************************
  always_comb begin
    hit        = |(gi.events & gi.mask);
    next_state = state;
    unique case (state)
      DVIG_IDLE: begin
        if (hit && gi.prio != PRIO_OFF) begin
          next_state = DVIG_REQUEST;
        end
      end
      DVIG_REQUEST: begin
        // request holds until its level is acknowledged or its priority is set to 0
        if (gi.prio == PRIO_OFF) begin
          next_state = DVIG_IDLE;
        end else if (gi.iack_hit) begin
          next_state = DVIG_ACKED;
        end
      end
      DVIG_ACKED: begin
        // one idle cycle after acknowledge so the host sees the line drop
        next_state = DVIG_IDLE;
      end
      default: next_state = DVIG_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= DVIG_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign gi.active    = (state == DVIG_REQUEST);
  assign gi.irq_lines = gi.active ? dvig_level_onehot(gi.prio) : LEVELS_NONE;
endmodule : dvig_generator
`default_nettype wire

// *** hdl/dvig_top.sv ***
// module: dual VME interrupt generator top level
`timescale 1ns/1ps
`default_nettype none
module dvig_top
  import dvig_pkg::*;
(
  input  wire logic                clk,                 // module clock, 10 MHz
  input  wire logic                rst_b,               // async reset, active low
  input  wire logic                ce,                  // clock enable, freezes all state
  // event sources from same-clock measurement logic
  input  wire logic                evt_fifo_not_empty,  // fifo holds a word
  input  wire logic                evt_block_ready,     // full block in fifo
  input  wire logic                evt_armed_waiting,   // armed, waiting for trigger
  input  wire logic                evt_acquisition_done,// stopped taking data
  input  wire logic                evt_input_overrange, // input exceeded range
  input  wire logic                evt_converter_fault, // converter hardware fault
  // settings port
  input  wire logic                generator_index,     // generator selected, 0 or 1
  input  wire logic                wr_mask,             // write mask strobe
  input  wire logic                wr_prio,             // write priority strobe
  input  wire logic [NUM_EVT-1:0]  wr_mask_data,        // mask to write
  input  wire logic [PRIO_W-1:0]   wr_prio_data,        // priority to write
  input  wire logic [STATID_W-1:0] wr_statid_data,      // status/id to write with mask
  output logic      [NUM_EVT-1:0]  rd_mask,             // mask of selected generator
  output logic      [PRIO_W-1:0]   rd_prio,             // priority of selected generator
  // backplane side, pins from outside the clock domain
  output logic      [LEVELS-1:0]   irq_b,               // request lines, active low
  input  wire logic                iack_in,             // acknowledge cycle strobe
  input  wire logic [PRIO_W-1:0]   iack_level,          // level being acknowledged
  output logic                     iack_done,           // status/id valid pulse
  output logic      [STATID_W-1:0] iack_statid,         // returned status/id word
  output logic      [NUM_GEN-1:0]  gen_active           // per-generator request state
);
  dvig_mask_t            mask   [NUM_GEN];
  dvig_mask_t            next_mask [NUM_GEN];
  dvig_prio_t            prio   [NUM_GEN];
  dvig_prio_t            next_prio [NUM_GEN];
  logic [STATID_W-1:0]   statid [NUM_GEN];
  logic [STATID_W-1:0]   next_statid [NUM_GEN];
  logic [NUM_EVT-1:0]    events;
  logic [LEVELS-1:0]     lines  [NUM_GEN];
  logic [NUM_GEN-1:0]    active;
  logic [NUM_GEN-1:0]    ack_sel;
  logic                  iack_s1;
  logic                  iack_s2;
  logic                  iack_s3;
  logic [PRIO_W-1:0]     lvl_s1;
  logic [PRIO_W-1:0]     lvl_s2;
  logic                  iack_rise;
  logic                  next_iack_done;
  logic [STATID_W-1:0]   next_iack_statid;
  logic [LEVELS-1:0]     next_irq_b;

  // ****************************************************************
  // event vector
  // ****************************************************************
  always_comb begin
    events = '0;
    events[EVT_FIFO_NOT_EMPTY]  = evt_fifo_not_empty;
    events[EVT_BLOCK_READY]     = evt_block_ready;
    events[EVT_ARMED_WAITING]   = evt_armed_waiting;
    events[EVT_ACQ_DONE]        = evt_acquisition_done;
    events[EVT_INPUT_OVERRANGE] = evt_input_overrange;
    events[EVT_CONVERTER_FAULT] = evt_converter_fault;
  end

  // ****************************************************************
  // settings registers
  // ****************************************************************
  always_comb begin
    for (int g = 0; g < NUM_GEN; g++) begin
      next_mask[g]   = mask[g];
      next_prio[g]   = prio[g];
      next_statid[g] = statid[g];
      if (generator_index == g[0]) begin
        if (wr_mask) begin
          next_mask[g]   = wr_mask_data;
          next_statid[g] = wr_statid_data;
        end
        if (wr_prio) begin
          next_prio[g] = wr_prio_data;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int g = 0; g < NUM_GEN; g++) begin
        mask[g]   <= MASK_RESET;
        prio[g]   <= PRIO_RESET;
        statid[g] <= STATID_RESET;
      end
    end else if (ce) begin
      for (int g = 0; g < NUM_GEN; g++) begin
        mask[g]   <= next_mask[g];
        prio[g]   <= next_prio[g];
        statid[g] <= next_statid[g];
      end
    end
  end

  assign rd_mask = mask[generator_index];
  assign rd_prio = prio[generator_index];

  // ****************************************************************
  // acknowledge input synchronisers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      iack_s1 <= 1'b0;
      iack_s2 <= 1'b0;
      iack_s3 <= 1'b0;
      lvl_s1  <= PRIO_OFF;
      lvl_s2  <= PRIO_OFF;
    end else if (ce) begin
      iack_s1 <= iack_in;
      iack_s2 <= iack_s1;
      iack_s3 <= iack_s2;
      lvl_s1  <= iack_level;
      lvl_s2  <= lvl_s1;
    end
  end

  // level bus is sampled with the strobe; host holds it stable through the cycle
  assign iack_rise = iack_s2 && !iack_s3;

  // ****************************************************************
  // generators
  // ****************************************************************
  genvar gv;
  generate
    for (gv = 0; gv < NUM_GEN; gv++) begin : g_gen
      dvig_gen_if gi ();
      assign gi.mask     = mask[gv];
      assign gi.prio     = prio[gv];
      assign gi.events   = events;
      assign gi.iack_hit = ack_sel[gv];
      assign active[gv]  = gi.active;
      assign lines[gv]   = gi.irq_lines;
      dvig_generator u_gen (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .gi    (gi)
      );
    end
  endgenerate

  // ****************************************************************
  // acknowledge arbitration and output registers
  // ****************************************************************
  always_comb begin
    // generator 0 answers first when both share the acknowledged level
    ack_sel = '0;
    next_iack_done   = 1'b0;
    next_iack_statid = iack_statid;
    if (iack_rise && lvl_s2 != PRIO_OFF) begin
      if (active[0] && prio[0] == lvl_s2) begin
        ack_sel[0]       = 1'b1;
        next_iack_done   = 1'b1;
        next_iack_statid = statid[0];
      end else if (active[1] && prio[1] == lvl_s2) begin
        ack_sel[1]       = 1'b1;
        next_iack_done   = 1'b1;
        next_iack_statid = statid[1];
      end
    end
    next_irq_b = ~(lines[0] | lines[1]);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      iack_done   <= 1'b0;
      iack_statid <= STATID_RESET;
      irq_b       <= ~LEVELS_NONE;
    end else if (ce) begin
      iack_done   <= next_iack_done;
      iack_statid <= next_iack_statid;
      irq_b       <= next_irq_b;
    end
  end

  assign gen_active = active;
endmodule : dvig_top
`default_nettype wire

// *** testbench/dvig_top_sva.sv ***
// checker: timing relations at the dual interrupt generator ports
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module dvig_top_chk
  import dvig_pkg::*;
(
  input wire logic               clk,                  // clock
  input wire logic               rst_b,                // reset
  input wire logic               ce,                   // clock enable
  input wire logic               evt_fifo_not_empty,   // event
  input wire logic               evt_block_ready,      // event
  input wire logic               evt_armed_waiting,    // event
  input wire logic               evt_acquisition_done, // event
  input wire logic               evt_input_overrange,  // event
  input wire logic               evt_converter_fault,  // event
  input wire logic               generator_index,      // select
  input wire logic               wr_mask,              // strobe
  input wire logic               wr_prio,              // strobe
  input wire logic [NUM_EVT-1:0] wr_mask_data,         // data
  input wire logic [PRIO_W-1:0]  wr_prio_data,         // data
  input wire logic [NUM_EVT-1:0] rd_mask,              // readback
  input wire logic [PRIO_W-1:0]  rd_prio,              // readback
  input wire logic [LEVELS-1:0]  irq_b,                // lines
  input wire logic               iack_in,              // ack strobe
  input wire logic               iack_done,            // answer
  input wire logic [NUM_GEN-1:0] gen_active            // state
);
  logic [NUM_EVT-1:0] ev;
  assign ev = {evt_converter_fault, evt_input_overrange, evt_acquisition_done,
               evt_armed_waiting, evt_block_ready, evt_fifo_not_empty};
  default clocking cb @(posedge clk); endclocking
  // frozen cycles carry no obligations here; a_hold covers them
  default disable iff (!rst_b || !ce);
  property p_irq; irq_b != 7'h7F |-> $past(gen_active) != 2'h0; endproperty
  a_irq: assert property (p_irq) else $error("line low, nothing pending");
  property p_pulse; iack_done |=> !iack_done; endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  property p_drop; $rose(iack_done) |-> ($past(gen_active) & ~gen_active) != 2'h0; endproperty
  a_drop: assert property (p_drop) else $error("answer without a dropped request");
  property p_sync; $rose(iack_in) |-> !iack_done ##1 !iack_done; endproperty
  a_sync: assert property (p_sync) else $error("answer ahead of synchroniser");
  property p_cause; $rose(gen_active[0]) || $rose(gen_active[1]) |-> $past(ev) != 6'h00;
  endproperty
  a_cause: assert property (p_cause) else $error("request with no event");
  property p_rdp; wr_prio |=> !$stable(generator_index) || rd_prio == $past(wr_prio_data);
  endproperty
  a_rdp: assert property (p_rdp) else $error("priority readback wrong");
  property p_rdm; wr_mask |=> !$stable(generator_index) || rd_mask == $past(wr_mask_data);
  endproperty
  a_rdm: assert property (p_rdm) else $error("mask readback wrong");
  property p_keep; wr_prio && !wr_mask |=> !$stable(generator_index) || $stable(rd_mask);
  endproperty
  a_keep: assert property (p_keep) else $error("mask moved on priority write");
  property p_hold;
    disable iff (!rst_b) !ce |=> $stable(irq_b) && $stable(gen_active) && $stable(iack_done);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved with enable low");
endmodule : dvig_top_chk
bind dvig_top dvig_top_chk dvig_top_chk_inst (.*);
`default_nettype wire

// *** testbench/dvig_vme_host.sv ***
// partner: host controller running interrupt acknowledge cycles
`timescale 1ns/1ps
`default_nettype none
// ****
// acknowledge cycle
// ****
module dvig_vme_host
  import dvig_pkg::*;
(
  input  wire logic                clk,         // clock
  input  wire logic                iack_done,   // answer strobe
  input  wire logic [STATID_W-1:0] iack_statid, // answer word
  output logic                     iack_in,     // ack strobe
  output logic      [PRIO_W-1:0]   iack_level   // level acked
);
  initial begin
    iack_in = 1'b0;
    iack_level = 3'h0;
  end
  // strobe held until the answer is sampled; a refused level runs out the wait
  task automatic ack(input logic [PRIO_W-1:0] lv, input int lag, output logic ok,
                     output logic [STATID_W-1:0] sid);
    repeat (lag + 2) @(posedge clk);
    iack_level <= lv;
    iack_in <= 1'b1;
    ok = 1'b0;
    sid = 8'h00;
    for (int n = 0; n < 12 && ok !== 1'b1; n++) begin
      @(posedge clk);
      ok = iack_done;
      sid = iack_statid;
    end
    iack_in <= 1'b0;
    iack_level <= ~lv; // released level keeps no stale value
  endtask : ack
endmodule : dvig_vme_host
`default_nettype wire

// *** testbench/dvig_top_tb_top.sv ***
// testbench: settings, requests and acknowledges of the dual generator
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module dvig_top_tb_top;
  import dvig_pkg::*;
  logic                clk = 1'b0, rst_b = 1'b0, ce = 1'b1, generator_index = 1'b0;
  logic                wr_mask = 1'b0, wr_prio = 1'b0, iack_in, iack_done, ok;
  logic                evt_fifo_not_empty = 1'b0, evt_block_ready = 1'b0;
  logic                evt_armed_waiting = 1'b0, evt_acquisition_done = 1'b0;
  logic                evt_input_overrange = 1'b0, evt_converter_fault = 1'b0;
  logic [NUM_EVT-1:0]  wr_mask_data = 6'h00, rd_mask;
  logic [PRIO_W-1:0]   wr_prio_data = 3'h0, rd_prio, iack_level;
  logic [STATID_W-1:0] wr_statid_data = 8'h00, iack_statid, sid;
  logic [LEVELS-1:0]   irq_b;
  logic [NUM_GEN-1:0]  gen_active;
  int                  n_fail = 0, cmp_count = 0;
  dvig_top dvig_top_inst (.*);
  dvig_vme_host dvig_vme_host_inst (.*);
  always #50 clk = ~clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic stop_test;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic wr(input logic g, m, p, input logic [5:0] mv, input logic [2:0] pv,
                    input logic [7:0] sv);
    @(posedge clk);
    generator_index <= g;
    wr_mask <= m;
    wr_prio <= p;
    wr_mask_data <= mv;
    wr_prio_data <= pv;
    wr_statid_data <= sv;
    @(posedge clk);
    wr_mask <= 1'b0;
    wr_prio <= 1'b0;
    #1;
  endtask : wr
  task automatic sev(input logic [5:0] v);
    @(posedge clk);
    {evt_converter_fault, evt_input_overrange, evt_acquisition_done,
     evt_armed_waiting, evt_block_ready, evt_fifo_not_empty} <= v;
    wt(2);
  endtask : sev
  task automatic ak(input logic [2:0] lv, input int lag, input logic eok,
                    input logic [7:0] es);
    dvig_vme_host_inst.ack(lv, lag, ok, sid);
    chk(ok, eok);
    if (eok && ok !== 1'b1) begin
      stop_test;
    end else if (eok) begin
      chk(sid, es);
    end
  endtask : ak
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk({rd_mask, rd_prio, irq_b, iack_done}, {6'h00, 3'h0, 7'h7F, 1'b0});
    $display("reset test done");
    wr(0, 0, 1, 6'h00, 3'h7, 8'h00);
    chk({rd_mask, rd_prio}, {6'h00, 3'h7});
    wr(0, 1, 0, 6'h01, 3'h0, 8'hA5);
    chk({rd_mask, rd_prio}, {6'h01, 3'h7});
    wr(1, 1, 1, 6'h3F, 3'h3, 8'h3C);
    chk({rd_mask, rd_prio}, {6'h3F, 3'h3});
    wr(0, 0, 0, 6'h00, 3'h0, 8'h00);
    chk({rd_mask, rd_prio}, {6'h01, 3'h7});
    wr(1, 1, 1, 6'h01, 3'h0, 8'h3C);
    $display("settings test done");
    for (int k = 0; k < 6; k++) begin
      wr(0, 1, 0, 6'h01 << k, 3'h0, 8'hA5);
      sev(~(6'h01 << k));
      chk(irq_b, 7'h7F);
      sev(6'h01 << k);
      chk({irq_b, gen_active}, {7'h3F, 2'b01});
      sev(6'h00);
      chk(irq_b, 7'h3F);
      ak(3'h7, k % 2, 1'b1, 8'hA5);
      wt(1);
      chk(irq_b, 7'h7F);
    end
    $display("event test done");
    sev(6'h01);
    chk(irq_b, 7'h7F);
    for (int p = 1; p < 8; p++) begin
      wr(1, 0, 1, 6'h00, p[2:0], 8'h00);
      wt(2);
      chk(irq_b, 7'(~(7'h01 << (p - 1))));
    end
    ak(3'h5, 0, 1'b0, 8'h00);
    ak(3'h7, 1, 1'b1, 8'h3C);
    wt(3);
    chk(gen_active, 2'b10);
    wr(0, 1, 1, 6'h01, 3'h2, 8'h5A);
    wt(2);
    chk(irq_b, 7'h3D);
    ak(3'h2, 0, 1'b1, 8'h5A);
    wr(1, 0, 1, 6'h00, 3'h0, 8'h00);
    wt(2);
    chk(gen_active, 2'b01);
    $display("level test done");
    @(posedge clk);
    ce <= 1'b0;
    wr(1, 0, 1, 6'h00, 3'h5, 8'h00);
    wt(2);
    chk({rd_prio, irq_b, gen_active}, {3'h0, 7'h7D, 2'b01});
    @(posedge clk);
    ce <= 1'b1;
    wt(2);
    chk({rd_prio, irq_b}, {3'h0, 7'h7D});
    $display("enable test done");
    @(posedge clk);
    rst_b <= 1'b0;
    wt(2);
    chk({rd_mask, rd_prio, irq_b, gen_active}, {6'h00, 3'h0, 7'h7F, 2'b00});
    @(posedge clk);
    rst_b <= 1'b1;
    wt(2);
    chk({irq_b, gen_active, iack_done}, {7'h7F, 2'b00, 1'b0});
    $display("mid-run reset test done");
    stop_test;
  end
endmodule : dvig_top_tb_top
`default_nettype wire
